// file: shared/smcs_pkg.sv
// Purpose: constants and types of the supply chip mode sequencer
// Assumes: 125 MHz system clock
// Notes: timing figures are defaults, long ones are top parameters
package smcs_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int RD_TIME_US = 10;
  localparam int RD_CYC = (RD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LW_TIME_MS = 200;
  localparam int LW_CYC = LW_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int WD_TIME_MS = 20;
  localparam int WD_CYC = WD_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CNT_W = 32;
  localparam int AW = 3;
  localparam int DW = 16;
  localparam int MODE_W = 2;
  localparam int NSYNC = 5;
  localparam int SY_TEST = 0;
  localparam int SY_SUP = 1;
  localparam int SY_WAKE = 2;
  localparam int SY_TSD = 3;
  localparam int SY_SHORT = 4;
  localparam logic [NSYNC-1:0] SYNC_RST = 5'h01;
  localparam logic [AW-1:0] A_MODE = 3'h0;
  localparam logic [AW-1:0] A_HW = 3'h1;
  localparam logic [AW-1:0] A_WD = 3'h2;
  localparam logic [AW-1:0] A_STAT = 3'h3;
  localparam logic [AW-1:0] A_WAKE = 3'h4;
  localparam logic [MODE_W-1:0] MODE_NORMAL = 2'h0;
  localparam logic [MODE_W-1:0] MODE_SLEEP = 2'h1;
  localparam logic [MODE_W-1:0] MODE_STOP = 2'h2;
  localparam logic [MODE_W-1:0] MODE_SOFT_RST = 2'h3;
  localparam int SECOND_CONFIGURATION_BIT_BIT = 0;
  localparam int MAX3_BIT = 0;
  localparam int WAKE_BIT = 0;
  localparam logic SECOND_CONFIGURATION_BIT_RST = 1'h1;
  localparam logic [1:0] MAX_RST = 2'h3;
  localparam logic [1:0] CFG_0 = 2'h0;
  localparam logic [1:0] CFG_1 = 2'h1;
  localparam logic [1:0] CFG_3 = 2'h3;
  typedef enum logic [5:0] {
    ST_INIT = 6'h01, ST_NORMAL = 6'h02, ST_STOP = 6'h04,
    ST_SLEEP = 6'h08, ST_RESTART = 6'h10, ST_FAILSAFE = 6'h20
  } smcs_state_t;
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } smcs_req_t;
  typedef struct packed {
    logic [1:0] pad;
    logic wd_fail;
    logic [1:0] rst_cnt;
    logic uv;
    logic spi_fail;
    logic dev;
    logic [1:0] cfg;
    smcs_state_t st;
  } smcs_stat_t;
endpackage : smcs_pkg

// file: src/smcs_mode_sequencer.sv
// Purpose: operating-mode sequencer and start-up configuration
// Assumes: host reaches registers over a plain one-cycle port
// Notes: async pins pass a three-stage synchroniser
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module smcs_mode_sequencer #(
  parameter int LW_CYCLES = smcs_pkg::LW_CYC,
  parameter int WD_CYCLES = smcs_pkg::WD_CYC
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  // register port
  input wire smcs_pkg::smcs_req_t BUS_REQ,
  output logic [smcs_pkg::DW-1:0] BUS_RDATA,
  // supervision pins
  input wire logic MAIN_SUPPLY_OK,
  input wire logic WAKE_IN,
  input wire logic THERMAL_SD_IN,
  input wire logic SUPPLY_SHORT_IN,
  // shared fail output / test pin
  input wire logic TEST_PIN_IN,
  output logic TEST_PIN_OUT,
  output logic TEST_PIN_OE,
  output logic TEST_PULLUP_EN,
  // outputs to the system
  output logic FAIL_OUT_N,
  output logic RESET_OUT_N,
  output logic MAIN_REG_EN,
  output logic INT_N
);
  import smcs_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] s1_reg;
  logic [NSYNC-1:0] s2_reg;
  logic [NSYNC-1:0] s3_reg;
  logic [NSYNC-1:0] filt_reg;
  assign pin_raw = {SUPPLY_SHORT_IN, THERMAL_SD_IN, WAKE_IN, MAIN_SUPPLY_OK, TEST_PIN_IN};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge CLK_SYS)
      begin
        if (SRST)
        begin
          s1_reg[gi] <= SYNC_RST[gi];
          s2_reg[gi] <= SYNC_RST[gi];
          s3_reg[gi] <= SYNC_RST[gi];
          filt_reg[gi] <= SYNC_RST[gi];
        end
        else
        begin
          s1_reg[gi] <= pin_raw[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi])
            filt_reg[gi] <= s3_reg[gi];
        end
      end
    end
  endgenerate

  wire test_lvl = filt_reg[SY_TEST];
  wire sup_ok = filt_reg[SY_SUP];
  wire wake = filt_reg[SY_WAKE];
  wire tsd = filt_reg[SY_TSD];
  wire fail_crit = tsd | filt_reg[SY_SHORT];

  ////////////////////////////////////////////////////////////////////
  // register decode
  function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] b);
    return a == b;
  endfunction : hit

  smcs_state_t st_reg;
  smcs_state_t st_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] wd_cnt_reg;
  logic [MODE_W-1:0] mode_reg;
  logic second_configuration_bit_reg;
  logic max3_reg;
  logic dev_reg;
  logic cfg_done_reg;
  logic rel_reg;
  logic lw_phase_reg;
  logic miss_reg;
  logic [1:0] rst_cnt_reg;
  logic wd_fail_reg;
  logic spi_fail_reg;
  logic uv_reg;
  logic wake_flag_reg;
  logic wake_d_reg;
  logic fail_reg;
  logic rst_n_reg;
  logic main_en_reg;
  logic int_n_reg;
  logic pull_reg;
  logic [DW-1:0] rdata_reg;

  wire is_init = st_reg == ST_INIT;
  wire is_norm = st_reg == ST_NORMAL;
  wire is_stop = st_reg == ST_STOP;
  wire is_sleep = st_reg == ST_SLEEP;
  wire is_rst = st_reg == ST_RESTART;
  wire [MODE_W-1:0] mode_val = BUS_REQ.wdata[MODE_W-1:0];
  wire wr_mode = BUS_REQ.wr & hit(BUS_REQ.addr, A_MODE);
  wire wr_hw = BUS_REQ.wr & hit(BUS_REQ.addr, A_HW);
  wire wr_wd = BUS_REQ.wr & hit(BUS_REQ.addr, A_WD);
  wire wr_stat = BUS_REQ.wr & hit(BUS_REQ.addr, A_STAT);
  wire wr_wake = BUS_REQ.wr & hit(BUS_REQ.addr, A_WAKE);
  wire soft_rst = wr_mode & (mode_val == MODE_SOFT_RST) & ~is_sleep;
  wire stop_ok = (wr_mode & (mode_val == MODE_NORMAL)) | soft_rst | wr_wd | wr_stat | wr_wake;
  wire stop_sleep = is_stop & wr_mode & (mode_val == MODE_SLEEP);
  wire refused = is_stop & BUS_REQ.wr & ~stop_ok;
  wire wr_en = BUS_REQ.wr & ~is_sleep & ~refused;
  wire any_cmd = (BUS_REQ.wr | BUS_REQ.rd) & rel_reg;
  wire rd_done = cnt_reg == CNT_W'(RD_CYC);
  wire wake_rise = wake & ~wake_d_reg;
  wire [1:0] cfg = dev_reg ? CFG_0 : (second_configuration_bit_reg ? CFG_1 : CFG_3);

  ////////////////////////////////////////////////////////////////////
  // watchdog
  wire wd_run = ((is_init & rel_reg) | is_norm | is_stop) & ~dev_reg;
  wire [CNT_W-1:0] wd_lim = lw_phase_reg ? CNT_W'(LW_CYCLES - 1) : CNT_W'(WD_CYCLES - 1);
  wire wd_trig = wr_wd & wr_en;
  wire wd_miss = wd_run & ~wd_trig & (wd_cnt_reg == wd_lim);
  wire wd_qual = wd_miss & ((cfg == CFG_1) | miss_reg);
  wire wd_restart = wd_qual & ~(max3_reg & (rst_cnt_reg == MAX_RST));

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST | soft_rst | ~wd_run | wd_trig | wd_miss)
      wd_cnt_reg <= '0;
    else
      wd_cnt_reg <= wd_cnt_reg + CNT_W'(1);
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST | soft_rst)
    begin
      miss_reg <= 1'b0;
      rst_cnt_reg <= '0;
      fail_reg <= 1'b0;
    end
    else
    begin
      if (wd_trig | wd_qual)
        miss_reg <= 1'b0;
      else if (wd_miss)
        miss_reg <= 1'b1;
      if (wd_trig)
        rst_cnt_reg <= '0;
      else if (wd_restart)
        rst_cnt_reg <= rst_cnt_reg + 2'h1;
      if (wd_qual)
        fail_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST | soft_rst)
      lw_phase_reg <= 1'b1;
    else if (is_rst)
      lw_phase_reg <= 1'b1;
    else if (wd_trig)
      lw_phase_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // mode state machine
  always_comb
  begin
    st_next = st_reg;
    case (st_reg)
      ST_INIT:
        if (wd_restart)
          st_next = ST_RESTART;
        else if (any_cmd & ~soft_rst)
          st_next = ST_NORMAL;
      ST_NORMAL, ST_STOP:
        if (fail_crit)
          st_next = ST_FAILSAFE;
        else if (~sup_ok | wd_restart | stop_sleep)
          st_next = ST_RESTART;
        else if (is_norm & wr_mode & (mode_val == MODE_SLEEP))
          st_next = ST_SLEEP;
        else if (is_norm & wr_mode & (mode_val == MODE_STOP))
          st_next = ST_STOP;
        else if (is_stop & wr_mode & (mode_val == MODE_NORMAL))
          st_next = ST_NORMAL;
      ST_SLEEP:
        if (fail_crit)
          st_next = ST_FAILSAFE;
        else if (wake | wake_flag_reg)
          st_next = ST_RESTART;
      ST_RESTART:
        if (fail_crit)
          st_next = ST_FAILSAFE;
        else if (sup_ok & rd_done)
          st_next = ST_NORMAL;
      ST_FAILSAFE:
        if (wake & ~tsd)
          st_next = ST_RESTART;
      default:
        st_next = ST_INIT;
    endcase
    if (soft_rst)
      st_next = ST_INIT;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      st_reg <= ST_INIT;
    else
      st_reg <= st_next;
  end

  // delay counter restarts with each mode and while supply is low
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST | (st_next != st_reg) | ~sup_ok)
      cnt_reg <= '0;
    else if (~rd_done)
      cnt_reg <= cnt_reg + CNT_W'(1);
  end

  ////////////////////////////////////////////////////////////////////
  // start-up configuration and reset release
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST | soft_rst)
    begin
      dev_reg <= 1'b0;
      cfg_done_reg <= 1'b0;
      rel_reg <= 1'b0;
    end
    else
    begin
      if (is_init & ~cfg_done_reg & sup_ok & (cnt_reg == CNT_W'(RD_CYC - 1)))
      begin
        dev_reg <= ~test_lvl;
        cfg_done_reg <= 1'b1;
      end
      if (is_init & rd_done & sup_ok)
        rel_reg <= 1'b1;
    end
  end

  // outputs decoded from the next mode
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      rst_n_reg <= 1'b0;
      main_en_reg <= 1'b1;
      pull_reg <= 1'b1;
    end
    else
    begin
      rst_n_reg <= (st_next == ST_NORMAL) | (st_next == ST_STOP) |
                   ((st_next == ST_INIT) & (rel_reg | (rd_done & sup_ok)));
      main_en_reg <= (st_next != ST_SLEEP) & (st_next != ST_FAILSAFE);
      pull_reg <= st_next == ST_INIT;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST | soft_rst)
    begin
      mode_reg <= MODE_NORMAL;
      second_configuration_bit_reg <= SECOND_CONFIGURATION_BIT_RST;
      max3_reg <= 1'b0;
    end
    else
    begin
      if ((st_next == ST_RESTART) & ~is_rst)
        mode_reg <= MODE_NORMAL;
      else if (wr_mode & wr_en & ~is_init & ~is_rst & ~stop_sleep)
        mode_reg <= mode_val;
      if (wr_hw & wr_en)
        second_configuration_bit_reg <= BUS_REQ.wdata[SECOND_CONFIGURATION_BIT_BIT];
      if (wr_wd & wr_en)
        max3_reg <= BUS_REQ.wdata[MAX3_BIT];
    end
  end

  // status flags, set wins over clear, except that init clears the wake flag over a set
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST | soft_rst)
    begin
      spi_fail_reg <= 1'b0;
      uv_reg <= 1'b0;
      wd_fail_reg <= 1'b0;
      wake_flag_reg <= 1'b0;
      wake_d_reg <= 1'b0;
    end
    else
    begin
      wake_d_reg <= wake;
      if (refused)
        spi_fail_reg <= 1'b1;
      else if (wr_stat)
        spi_fail_reg <= 1'b0;
      if ((is_norm | is_stop) & ~sup_ok)
        uv_reg <= 1'b1;
      else if (wr_stat)
        uv_reg <= 1'b0;
      if (wd_miss)
        wd_fail_reg <= 1'b1;
      else if (wr_stat)
        wd_fail_reg <= 1'b0;
      if (is_init)
        wake_flag_reg <= 1'b0;
      else if (wake_rise)
        wake_flag_reg <= 1'b1;
      else if (wr_wake & BUS_REQ.wdata[WAKE_BIT])
        wake_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      int_n_reg <= 1'b1;
    else
      int_n_reg <= ~(wake_flag_reg & (is_norm | is_stop));
  end

  ////////////////////////////////////////////////////////////////////
  // read path
  smcs_stat_t stat;
  logic [DW-1:0] rd_mux;
  assign stat = '{pad: 2'h0, wd_fail: wd_fail_reg, rst_cnt: rst_cnt_reg, uv: uv_reg,
                  spi_fail: spi_fail_reg, dev: dev_reg, cfg: cfg, st: st_reg};
  assign rd_mux = hit(BUS_REQ.addr, A_MODE) ? DW'(mode_reg) :
                  hit(BUS_REQ.addr, A_HW) ? DW'(second_configuration_bit_reg) :
                  hit(BUS_REQ.addr, A_WD) ? DW'(max3_reg) :
                  hit(BUS_REQ.addr, A_STAT) ? DW'(stat) :
                  hit(BUS_REQ.addr, A_WAKE) ? DW'(wake_flag_reg) : '0;

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      rdata_reg <= '0;
    else
      rdata_reg <= (BUS_REQ.rd & ~is_sleep) ? rd_mux : '0;
  end

  assign BUS_RDATA = rdata_reg;
  assign RESET_OUT_N = rst_n_reg;
  assign MAIN_REG_EN = main_en_reg;
  assign INT_N = int_n_reg;
  assign FAIL_OUT_N = ~fail_reg;
  assign TEST_PIN_OUT = 1'b0;
  assign TEST_PIN_OE = fail_reg & ~pull_reg;
  assign TEST_PULLUP_EN = pull_reg;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  sequence s_stop_sleep_req;
    is_stop && wr_mode && (mode_val == MODE_SLEEP) && !fail_crit;
  endsequence
  sequence s_restart_done;
    is_rst && sup_ok && rd_done && !fail_crit && !soft_rst;
  endsequence

  a_soft_reset_init: assert property (soft_rst |=> is_init ##1 !RESET_OUT_N)
    else $error("soft reset did not enter init");
  a_restart_exit_normal: assert property (s_restart_done |=> is_norm && RESET_OUT_N)
    else $error("restart did not release to normal");
  a_failsafe_reg_off: assert property (st_reg == ST_FAILSAFE |-> !MAIN_REG_EN && !RESET_OUT_N)
    else $error("regulator on in fail-safe");
  a_dev_wd_halt: assert property (dev_reg && !is_init |-> wd_cnt_reg == '0 && !wd_miss)
    else $error("watchdog ran in development mode");
  a_mode_field_clear: assert property (is_rst |-> mode_reg == MODE_NORMAL)
    else $error("mode field not cleared in restart");
  a_init_cmd_normal: assert property (is_init && any_cmd && !soft_rst && !wd_restart |=> is_norm)
    else $error("command in init did not reach normal");
  a_reset_hold_low: assert property (is_init && !sup_ok && !rel_reg |=> !RESET_OUT_N [*2])
    else $error("reset released with supply low");
  a_init_wake_drop: assert property (is_init |=> !wake_flag_reg)
    else $error("wake kept during init");
  a_stop_refuse_write: assert property (is_stop && wr_hw |=> spi_fail_reg && $stable(second_configuration_bit_reg))
    else $error("write accepted in stop");
  a_stop_sleep_fail: assert property (s_stop_sleep_req |=> is_rst && spi_fail_reg)
    else $error("stop to sleep not refused");
  a_sleep_pending_wake: assert property (is_sleep && wake_flag_reg && !fail_crit |=> is_rst)
    else $error("sleep entered with pending wake");
  a_wd_limit_three: assert property (max3_reg && rst_cnt_reg == MAX_RST && wd_miss && sup_ok && !fail_crit && !stop_sleep |=> !is_rst)
    else $error("reset after limit reached");
  a_uv_not_init: assert property (is_init && !rel_reg && !uv_reg |=> !uv_reg && FAIL_OUT_N)
    else $error("undervoltage or fail raised in init");
endmodule : smcs_mode_sequencer
`default_nettype wire

// file: verification/smcs_host_model.sv
// Purpose: host controller on the register port
// Assumes: read data stand one cycle after the read strobe
// Notes: released request lines carry inverted values
`timescale 1ns/1ns
`default_nettype none
module smcs_host_model (
  // clock
  input wire logic clk,
  // device answer
  input wire logic [smcs_pkg::DW-1:0] rdata,
  // request
  output var smcs_pkg::smcs_req_t req
);
  import smcs_pkg::*;
  initial req = '0;
  ////////////////////////////////////////////////////////////////////////
  // one 16-bit write frame
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask : wr
  // one 16-bit read frame
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '{addr: ~a, wdata: 16'hFFFF, wr: 1'b0, rd: 1'b0};
    #1;
    d = rdata;
  endtask : rd
endmodule : smcs_host_model
`default_nettype wire

// file: verification/test_supply_chip_mode_sequencer.sv
// Purpose: self-checking bench of the mode sequencer
// Assumes: shortened watchdog windows, host model on the port
// Notes: status expectations come from the bench model fields, other checks use fixed values
`timescale 1ns/1ns
`default_nettype none
module test_supply_chip_mode_sequencer;
  import smcs_pkg::*;
  localparam int LW_T = 200;
  localparam int WD_T = 100;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic sup_ok = 1'b0;
  logic wake = 1'b0;
  logic tsd = 1'b0;
  logic sc = 1'b0;
  logic pin_ext = 1'b1;
  logic [31:0] rng = 32'h00002D7C;
  int bad_count = 0;
  int n_tests = 0;
  int m_st = ST_INIT;
  int m_cfg = 0;
  int m_dev = 0;
  int n;
  int q_fall[$];
  logic [DW-1:0] v;
  smcs_req_t req;
  logic [DW-1:0] rdata;
  logic tp_out;
  logic tp_oe;
  logic tp_pu;
  logic fail_n;
  logic rst_n;
  logic reg_en;
  logic int_n;
  wire pin_lvl;
  assign pin_lvl = tp_oe ? tp_out : pin_ext;
  always #4 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////
  smcs_mode_sequencer #(.LW_CYCLES(LW_T), .WD_CYCLES(WD_T)) DUT (
    .CLK_SYS(clk_sys), .SRST(srst), .BUS_REQ(req), .BUS_RDATA(rdata),
    .MAIN_SUPPLY_OK(sup_ok), .WAKE_IN(wake), .THERMAL_SD_IN(tsd),
    .SUPPLY_SHORT_IN(sc), .TEST_PIN_IN(pin_lvl), .TEST_PIN_OUT(tp_out),
    .TEST_PIN_OE(tp_oe), .TEST_PULLUP_EN(tp_pu), .FAIL_OUT_N(fail_n),
    .RESET_OUT_N(rst_n), .MAIN_REG_EN(reg_en), .INT_N(int_n)
  );
  smcs_host_model host (.clk(clk_sys), .rdata(rdata), .req(req));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic wrap_up();
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic chk(input string s, input logic [DW-1:0] e, input logic [DW-1:0] g);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic chb(input string s, input logic e, input logic g);
    chk(s, 16'(e), 16'(g));
  endtask : chb
  task automatic see_st();
    host.rd(A_STAT, v);
    chk("status", 16'((m_dev << 8) | (m_cfg << 6) | m_st), v & 16'h01FF);
  endtask : see_st
  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic wait_rst(input logic lvl, input int lim);
    n = 0;
    while (rst_n !== lvl && n < lim)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask : wait_rst
  task automatic pulse_wake();
    @(posedge clk_sys);
    wake <= 1'b1;
    repeat (8) @(posedge clk_sys);
    wake <= 1'b0;
    tick(8);
  endtask : pulse_wake
  task automatic bounce();
    wait_rst(1'b0, 40);
    chb("restart_low", 1'b0, rst_n);
    wait_rst(1'b1, RD_CYC + 40);
    chb("restart_high", 1'b1, rst_n);
    m_st = ST_NORMAL;
  endtask : bounce
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    bad_count++;
    wrap_up();
  end
  initial
  begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    tick(20);
    chb("reset_out", 1'b0, rst_n);
    chb("pullup", 1'b1, tp_pu);
    chb("fail_out", 1'b1, fail_n);
    chb("pin_out", 1'b0, tp_out);
    pulse_wake();
    host.rd(A_WAKE, v);
    chk("wake_flag", 16'h0000, v);
    host.rd(A_STAT, v);
    chk("state", 16'(ST_INIT), 16'(v[5:0]));
    chb("uv_flag", 1'b0, v[10]);
    @(posedge clk_sys);
    sup_ok <= 1'b1;
    wait_rst(1'b1, RD_CYC + 40);
    chb("release", 1'b1, rst_n);
    chb("delay", 1'b1, n >= RD_CYC);
    rng = xs(rng);
    host.wr(3'h7, rng[15:0]);
    m_st = ST_NORMAL;
    m_cfg = CFG_1;
    see_st();
    wait_rst(1'b0, LW_T + 40);
    chb("lw_miss", 1'b1, n >= LW_T - 30 && n <= LW_T + 5);
    chb("fail_out", 1'b0, fail_n);
    bounce();
    see_st();
    chb("wd_fail", 1'b1, v[13]);
    host.wr(A_WD, 16'h0001);
    repeat (3)
    begin
      wait_rst(1'b0, LW_T + 40);
      if (rst_n === 1'b0)
        q_fall.push_back(n);
      wait_rst(1'b1, RD_CYC + 40);
    end
    tick(3 * LW_T);
    chk("fall_count", 16'h0003, 16'(q_fall.size()));
    chb("reset_out", 1'b1, rst_n);
    see_st();
    chk("rst_count", 16'(MAX_RST), 16'(v[12:11]));
    host.wr(A_MODE, 16'(MODE_SOFT_RST));
    @(posedge clk_sys);
    pin_ext <= 1'b0;
    bounce();
    chb("fail_out", 1'b1, fail_n);
    chb("pullup", 1'b1, tp_pu);
    chb("pin_oe", 1'b0, tp_oe);
    host.wr(A_STAT, 16'h0000);
    @(posedge clk_sys);
    pin_ext <= 1'b1;
    m_cfg = CFG_0;
    m_dev = 1;
    see_st();
    chb("pullup", 1'b0, tp_pu);
    pulse_wake();
    chb("int_out", 1'b0, int_n);
    see_st();
    host.wr(A_MODE, 16'(MODE_SLEEP));
    bounce();
    host.wr(A_WAKE, 16'h0001);
    host.rd(A_WAKE, v);
    chk("wake_flag", 16'h0000, v);
    host.wr(A_MODE, 16'(MODE_STOP));
    m_st = ST_STOP;
    see_st();
    chb("reg_en", 1'b1, reg_en);
    host.wr(A_HW, 16'h0000);
    see_st();
    chb("spi_fail", 1'b1, v[9]);
    host.rd(A_HW, v);
    chk("hardware_control_register", 16'(SECOND_CONFIGURATION_BIT_RST), v);
    host.wr(A_STAT, 16'h0000);
    host.wr(A_MODE, 16'(MODE_SLEEP));
    bounce();
    see_st();
    chb("spi_fail", 1'b1, v[9]);
    host.rd(A_MODE, v);
    chk("mode_field", 16'(MODE_NORMAL), v);
    host.wr(A_MODE, 16'(MODE_STOP));
    host.wr(A_MODE, 16'(MODE_NORMAL));
    see_st();
    host.wr(A_MODE, 16'(MODE_SLEEP));
    tick(4);
    chb("reg_en", 1'b0, reg_en);
    pulse_wake();
    bounce();
    see_st();
    @(posedge clk_sys);
    sup_ok <= 1'b0;
    wait_rst(1'b0, 40);
    chb("uv_reset", 1'b0, rst_n);
    @(posedge clk_sys);
    sup_ok <= 1'b1;
    bounce();
    see_st();
    chb("uv_flag", 1'b1, v[10]);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk_sys);
      tsd <= (k == 0);
      sc <= (k == 1);
      tick(10);
      chb("reg_en", 1'b0, reg_en);
      if (k == 0)
      begin
        pulse_wake();
        chb("reg_en", 1'b0, reg_en);
      end
      @(posedge clk_sys);
      tsd <= 1'b0;
      sc <= 1'b0;
      tick(10);
      pulse_wake();
      bounce();
      see_st();
    end
    tick(3 * LW_T);
    chb("reset_out", 1'b1, rst_n);
    see_st();
    chb("wd_fail", 1'b0, v[13]);
    host.wr(A_MODE, 16'(MODE_SOFT_RST));
    bounce();
    rng = xs(rng);
    host.wr(3'h7, rng[15:0]);
    host.wr(A_HW, 16'h0000);
    host.wr(A_WD, 16'h0000);
    wait_rst(1'b0, 3 * WD_T);
    chb("second_miss", 1'b1, n > WD_T + 10 && rst_n === 1'b0);
    chb("fail_out", 1'b0, fail_n);
    wrap_up();
  end
endmodule : test_supply_chip_mode_sequencer
`default_nettype wire
